// ### hdl/clo_params.svh
// Constants for the configurable logic operator bank
`ifndef CLO_PARAMS_SVH
`define CLO_PARAMS_SVH

// Multi-input gate operator input counts
`define CLO_GATE_MIN_IN 4'h2
`define CLO_GATE_MAX_IN 4'h8
// Logic macro: total inputs and per-gate counts
`define CLO_MACRO_MAX_IN 8
`define CLO_MACRO_GATE_MIN 3'h1
`define CLO_MACRO_GATE_MAX 3'h7
// Final macro gate always sees the two first-level results
`define CLO_MACRO_FINAL_IN 4'h2
// Multiplexer input counts
`define CLO_MUX_MIN_IN 3'h2
`define CLO_MUX_MAX_IN 3'h4
// Digital comparator widths
`define CLO_CMP_MIN_IN 4'h2
`define CLO_CMP_MAX_IN 4'h8
`define CLO_CMP_SIG_W 4
// Gate count field width shared by all gate instances
`define CLO_CNT_W 4
// Reset value of every registered output
`define CLO_OUT_RST 1'h0

`endif

// ### hdl/clo_pkg.sv
// Types shared by the configurable logic operator bank
package clo_pkg;

  // Boolean function of a gate
  typedef enum logic [2:0] {
    CLO_FUNC_AND  = 3'h0,
    CLO_FUNC_NAND = 3'h1,
    CLO_FUNC_OR   = 3'h2,
    CLO_FUNC_NOR  = 3'h3,
    CLO_FUNC_XOR  = 3'h4,
    CLO_FUNC_XNOR = 3'h5,
    CLO_FUNC_NOT  = 3'h6
  } clo_func_e;

  // Relation of the digital comparator
  typedef enum logic [2:0] {
    CLO_REL_LT = 3'h0,
    CLO_REL_GE = 3'h1,
    CLO_REL_GT = 3'h2,
    CLO_REL_LE = 3'h3,
    CLO_REL_EQ = 3'h4,
    CLO_REL_NE = 3'h5
  } clo_rel_e;

  // Whole registered state of the operator bank
  typedef struct packed {
    logic gate_out;
    logic macro_out;
    logic first_out;
    logic second_out;
    logic sr_mem;
    logic mux_out;
    logic cmp_out;
  } clo_state_s;

endpackage

// ### hdl/clo_gate.sv
// Configurable multi-input Boolean gate, purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "clo_params.svh"

module clo_gate #(
  parameter int N = 8
) (
  // Gate operands and configuration
  input wire logic [N-1:0] in_bits,
  input wire logic [`CLO_CNT_W-1:0] in_count,
  input wire clo_pkg::clo_func_e func,
  // Result
  output logic result
);

  logic [N-1:0] and_v;
  logic [N-1:0] or_v;

  // Unused inputs must not disturb the result: 1 for AND, 0 for OR/XOR
  generate
    for (genvar i = 0; i < N; i++) begin : g_mask
      logic active;
      assign active = (`CLO_CNT_W'(i) < in_count);
      assign and_v[i] = active ? in_bits[i] : 1'h1;
      assign or_v[i] = active & in_bits[i];
    end
  endgenerate

  // Function select; a count of one passes input 0 straight through
  always_comb begin
    result = 1'h0;
    if (in_count == `CLO_CNT_W'(1)) begin
      result = in_bits[0];
    end else begin
      case (func)
        clo_pkg::CLO_FUNC_AND: result = &and_v;
        clo_pkg::CLO_FUNC_NAND: result = ~(&and_v);
        clo_pkg::CLO_FUNC_OR: result = |or_v;
        clo_pkg::CLO_FUNC_NOR: result = ~(|or_v);
        clo_pkg::CLO_FUNC_XOR: result = ^or_v;
        clo_pkg::CLO_FUNC_XNOR: result = ~(^or_v);
        clo_pkg::CLO_FUNC_NOT: result = ~in_bits[0];
        default: result = 1'h0;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### hdl/clo_operators.sv
// Configurable logic operator bank: gate, macro, multiplexer, comparator
// Functional notes
// RULE1 - Every operator input has its own inversion enable.
// RULE2 - AND output high only when all configured inputs high; 2 to 8.
// RULE3 - NAND output low only when all configured inputs high; 2 to 8.
// RULE4 - NOT has one input and outputs its complement.
// RULE5 - OR output high when any configured input high; 2 to 8.
// RULE6 - NOR output high only when all configured inputs low; 2 to 8.
// RULE7 - XOR gives odd parity of configured inputs; 2 to 8.
// RULE8 - XNOR gives complement of XOR; 2 to 8 inputs.
// RULE9 - Macro: two gates feed a third giving main output, 8 inputs max.
// RULE10 - Each first-level macro gate takes 1 to 7 inputs; 1 bypasses.
// RULE11 - Macro gates pick any gate type; final one may be SR flip-flop.
// RULE12 - Macro main output can be removed; gate 1/2 results exposable.
// RULE13 - Multiplexer passes data n when only choice line n asserted.
// RULE14 - Multiplexer output low when zero or several choice lines set.
// RULE15 - Constant mode: 2 to 8 inputs as unsigned, input 0 is LSB.
// RULE16 - Comparator relations LT, GE, GT, LE, EQ, NE; high while true.
// RULE17 - Constant mode only while signal comparison is off.
// RULE18 - Signal comparison compares 4-bit operand A with operand B.
// RULE19 - Outputs computed combinationally, registered each scan, reset low.
`timescale 1ns/1ns
`default_nettype none
`include "clo_params.svh"

module clo_operators #(
  parameter int GATE_IN = 8,
  parameter int MACRO_IN = `CLO_MACRO_MAX_IN,
  parameter int MUX_IN = 4,
  parameter int CMP_IN = 8,
  parameter int SIG_W = `CLO_CMP_SIG_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,

  // Stand-alone gate operator
  input wire logic [GATE_IN-1:0] gate_in,
  input wire logic [GATE_IN-1:0] gate_inv,
  input wire logic [`CLO_CNT_W-1:0] gate_count,
  input wire clo_pkg::clo_func_e gate_func,
  output logic gate_out,

  // Logic macro
  input wire logic [MACRO_IN-1:0] macro_in,
  input wire logic [MACRO_IN-1:0] macro_inv,
  input wire logic [2:0] macro_count1,
  input wire logic [2:0] macro_count2,
  input wire clo_pkg::clo_func_e macro_func1,
  input wire clo_pkg::clo_func_e macro_func2,
  input wire clo_pkg::clo_func_e macro_func3,
  input wire logic macro_final_sr,
  input wire logic macro_out_disable,
  input wire logic macro_first_gate_result_output_en,
  input wire logic macro_second_gate_result_output_en,
  output logic macro_out,
  output logic first_gate_result_output,
  output logic second_gate_result_output,

  // Multiplexer
  input wire logic [MUX_IN-1:0] mux_data,
  input wire logic [MUX_IN-1:0] mux_data_inv,
  input wire logic [MUX_IN-1:0] mux_choice_lines,
  input wire logic [MUX_IN-1:0] mux_choice_inv,
  input wire logic [2:0] mux_count,
  output logic mux_out,

  // Digital comparator
  input wire logic [CMP_IN-1:0] cmp_in,
  input wire logic [CMP_IN-1:0] cmp_inv,
  input wire logic [`CLO_CNT_W-1:0] cmp_count,
  input wire logic [CMP_IN-1:0] cmp_const,
  input wire clo_pkg::clo_rel_e cmp_rel,
  input wire logic cmp_signal_mode,
  input wire logic [SIG_W-1:0] operand_a_bits,
  input wire logic [SIG_W-1:0] operand_a_inv,
  input wire logic [SIG_W-1:0] operand_b_bits,
  input wire logic [SIG_W-1:0] operand_b_inv,
  output logic cmp_out
);

  // Relation test shared by both comparator modes
  function automatic logic clo_relate(
    input logic [CMP_IN-1:0] a,
    input logic [CMP_IN-1:0] b,
    input clo_pkg::clo_rel_e rel
  );
    logic res;
    res = 1'h0;
    case (rel)
      clo_pkg::CLO_REL_LT: res = (a < b); // RULE16
      clo_pkg::CLO_REL_GE: res = (a >= b);
      clo_pkg::CLO_REL_GT: res = (a > b);
      clo_pkg::CLO_REL_LE: res = (a <= b);
      clo_pkg::CLO_REL_EQ: res = (a == b);
      clo_pkg::CLO_REL_NE: res = (a != b);
      default: res = 1'h0;
    endcase
    return res;
  endfunction

  clo_pkg::clo_state_s state_q;
  clo_pkg::clo_state_s state_d;

  // ------------------------------------------------------------------
  // Input inversion: every input passes an XOR with its own enable
  // ------------------------------------------------------------------
  logic [GATE_IN-1:0] gate_eff;
  logic [MACRO_IN-1:0] macro_eff;
  logic [MUX_IN-1:0] mux_data_eff;
  logic [MUX_IN-1:0] mux_sel_eff;
  logic [CMP_IN-1:0] cmp_eff;
  logic [SIG_W-1:0] op_a_eff;
  logic [SIG_W-1:0] op_b_eff;

  // Inverted copies feed every operator below
  assign gate_eff = gate_in ^ gate_inv; // RULE1
  assign macro_eff = macro_in ^ macro_inv; // RULE1
  assign mux_data_eff = mux_data ^ mux_data_inv; // RULE1
  assign mux_sel_eff = mux_choice_lines ^ mux_choice_inv; // RULE1
  assign cmp_eff = cmp_in ^ cmp_inv; // RULE1
  assign op_a_eff = operand_a_bits ^ operand_a_inv; // RULE1
  assign op_b_eff = operand_b_bits ^ operand_b_inv; // RULE1

  // ------------------------------------------------------------------
  // Stand-alone gate
  // ------------------------------------------------------------------
  logic [`CLO_CNT_W-1:0] gate_cnt_c;
  logic gate_res;

  // Out-of-range counts are held to the legal span of two to eight
  always_comb begin
    if (gate_count < `CLO_GATE_MIN_IN) begin
      gate_cnt_c = `CLO_GATE_MIN_IN;
    end else if (gate_count > `CLO_GATE_MAX_IN) begin
      gate_cnt_c = `CLO_GATE_MAX_IN;
    end else begin
      gate_cnt_c = gate_count;
    end
  end

  // AND, NAND, OR, NOR, XOR, XNOR or single-input NOT
  clo_gate #(
    .N(GATE_IN)
  ) u_gate (
    .in_bits(gate_eff),
    .in_count(gate_cnt_c),
    .func(gate_func),
    .result(gate_res)
  );

  // ------------------------------------------------------------------
  // Logic macro: two first-level gates feeding a final gate
  // ------------------------------------------------------------------
  logic [2:0] mc1_c;
  logic [2:0] mc2_c;
  logic [MACRO_IN-1:0] g2_bits;
  logic g1_res;
  logic g2_res;
  logic g3_res;

  // A count of zero is taken as one; seven is the top of the field
  always_comb begin
    mc1_c = macro_count1;
    mc2_c = macro_count2;
    if (macro_count1 < `CLO_MACRO_GATE_MIN) begin
      mc1_c = `CLO_MACRO_GATE_MIN; // RULE10
    end
    if (macro_count2 < `CLO_MACRO_GATE_MIN) begin
      mc2_c = `CLO_MACRO_GATE_MIN; // RULE10
    end
  end

  // Gate 2 takes the inputs right after those of gate 1; anything
  // beyond the eight wired inputs reads as low, so an oversized split
  // simply sees zeros rather than wrapping round
  assign g2_bits = macro_eff >> mc1_c; // RULE9

  // First gate; count one bypasses it straight to the final gate
  clo_gate #(
    .N(MACRO_IN)
  ) u_macro_g1 (
    .in_bits(macro_eff),
    .in_count({1'h0, mc1_c}),
    .func(macro_func1),
    .result(g1_res)
  );

  // Second gate, same bypass on a count of one
  clo_gate #(
    .N(MACRO_IN)
  ) u_macro_g2 (
    .in_bits(g2_bits),
    .in_count({1'h0, mc2_c}),
    .func(macro_func2),
    .result(g2_res)
  );

  // Final gate combines the two first-level results
  clo_gate #(
    .N(2)
  ) u_macro_g3 (
    .in_bits({g2_res, g1_res}),
    .in_count(`CLO_MACRO_FINAL_IN),
    .func(macro_func3),
    .result(g3_res)
  );

  // ------------------------------------------------------------------
  // Multiplexer
  // ------------------------------------------------------------------
  logic [2:0] mux_cnt_c;
  logic [MUX_IN-1:0] mux_sel_act;
  logic mux_one_hot;
  logic mux_res;

  // Choice count held to two through four
  always_comb begin
    if (mux_count < `CLO_MUX_MIN_IN) begin
      mux_cnt_c = `CLO_MUX_MIN_IN;
    end else if (mux_count > `CLO_MUX_MAX_IN) begin
      mux_cnt_c = `CLO_MUX_MAX_IN;
    end else begin
      mux_cnt_c = mux_count;
    end
  end

  // Choice lines past the configured count are not wired in
  generate
    for (genvar i = 0; i < MUX_IN; i++) begin : g_mux_sel
      assign mux_sel_act[i] = mux_sel_eff[i] & (3'(i) < mux_cnt_c);
    end
  endgenerate

  // Exactly one line set; zero or several force the output low
  assign mux_one_hot = (mux_sel_act != '0) &&
    ((mux_sel_act & (mux_sel_act - 1'b1)) == '0); // RULE14
  // With a single line set the AND-OR picks exactly data n
  assign mux_res = mux_one_hot & (|(mux_sel_act & mux_data_eff)); // RULE13

  // ------------------------------------------------------------------
  // Digital comparator
  // ------------------------------------------------------------------
  logic [`CLO_CNT_W-1:0] cmp_cnt_c;
  logic [CMP_IN-1:0] cmp_val;
  logic [CMP_IN-1:0] cmp_ref;
  logic cmp_const_res;
  logic cmp_sig_res;

  // Bit count held to two through eight
  always_comb begin
    if (cmp_count < `CLO_CMP_MIN_IN) begin
      cmp_cnt_c = `CLO_CMP_MIN_IN;
    end else if (cmp_count > `CLO_CMP_MAX_IN) begin
      cmp_cnt_c = `CLO_CMP_MAX_IN;
    end else begin
      cmp_cnt_c = cmp_count;
    end
  end

  // Input 0 is the LSB; unused high bits read as zero
  generate
    for (genvar i = 0; i < CMP_IN; i++) begin : g_cmp_bits
      logic used;
      assign used = (`CLO_CNT_W'(i) < cmp_cnt_c);
      assign cmp_val[i] = cmp_eff[i] & used; // RULE15
      assign cmp_ref[i] = cmp_const[i] & used;
    end
  endgenerate

  // The constant is truncated to the configured width, so a constant
  // that does not fit the chosen bit count compares on its low bits
  assign cmp_const_res = clo_relate(cmp_val, cmp_ref, cmp_rel); // RULE15

  // Four-bit operands, zero-extended to the shared comparison width
  assign cmp_sig_res = clo_relate(CMP_IN'(op_a_eff), CMP_IN'(op_b_eff),
    cmp_rel); // RULE18

  // ------------------------------------------------------------------
  // Next state of all registered outputs
  // ------------------------------------------------------------------
  // Every result is taken from the current inputs in this cycle and
  // registered at the next scan edge, so each output lags its inputs by
  // exactly one clock; the SR memory is the only true feedback
  always_comb begin
    state_d = state_q;

    // Stand-alone gate result
    state_d.gate_out = gate_res; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8

    // SR memory: gate 1 sets, gate 2 resets, reset wins on a tie
    if (g2_res) begin
      state_d.sr_mem = 1'h0; // RULE11
    end else if (g1_res) begin
      state_d.sr_mem = 1'h1; // RULE11
    end

    // Main macro output, from the final gate or the SR memory
    if (macro_out_disable) begin
      state_d.macro_out = 1'h0; // RULE12
    end else if (macro_final_sr) begin
      // Follows the memory after this edge's update
      state_d.macro_out = state_d.sr_mem; // RULE11
    end else begin
      state_d.macro_out = g3_res; // RULE9
    end

    // Optional first-level result outputs
    state_d.first_out = macro_first_gate_result_output_en & g1_res; // RULE12
    state_d.second_out = macro_second_gate_result_output_en & g2_res; // RULE12

    // Multiplexer result
    state_d.mux_out = mux_res;

    // Constant mode applies only with signal comparison off
    if (cmp_signal_mode) begin
      state_d.cmp_out = cmp_sig_res; // RULE18
    end else begin
      state_d.cmp_out = cmp_const_res; // RULE17
    end
  end

  // One register stage for the whole bank; reset clears all to low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= '{default: `CLO_OUT_RST}; // RULE19
    end else begin
      state_q <= state_d; // RULE19
    end
  end

  // ------------------------------------------------------------------
  // Outputs straight from the state register
  // ------------------------------------------------------------------
  assign gate_out = state_q.gate_out;
  assign macro_out = state_q.macro_out;
  assign first_gate_result_output = state_q.first_out;
  assign second_gate_result_output = state_q.second_out;
  assign mux_out = state_q.mux_out;
  assign cmp_out = state_q.cmp_out;

endmodule

`default_nettype wire

// ### sim/clo_src.sv
// Model of the safety inputs feeding the stand-alone gate operator
`timescale 1ns/1ns
`default_nettype none
module clo_src (
  // Clock
  input wire logic clk_sys,
  // Request from the bench
  input wire logic src_en,
  input wire logic [7:0] src_req,
  // Lines towards the operators
  output logic [7:0] gate_in
);
  logic [7:0] last_q;
  // Remember the last level driven
  always_ff @(posedge clk_sys) begin
    if (src_en) last_q <= src_req;
  end
  // A released source shows the inverse so a stale level cannot pass
  assign gate_in = src_en ? src_req : ~last_q;
endmodule
`default_nettype wire

// ### sim/clo_monitor.sv
// Port-level assertion checker for the logic operator bank
`timescale 1ns/1ns
`default_nettype none
module clo_monitor #(
  parameter int GATE_IN = 8,
  parameter int MUX_IN = 4,
  parameter int CMP_IN = 8,
  parameter int SIG_W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Gate operator
  input wire logic [GATE_IN-1:0] gate_in,
  input wire logic [GATE_IN-1:0] gate_inv,
  input wire logic [3:0] gate_count,
  input wire clo_pkg::clo_func_e gate_func,
  input wire logic gate_out,
  // Macro
  input wire logic macro_out_disable,
  input wire logic macro_out,
  // Multiplexer
  input wire logic [MUX_IN-1:0] mux_data,
  input wire logic [MUX_IN-1:0] mux_data_inv,
  input wire logic [MUX_IN-1:0] mux_choice_lines,
  input wire logic [MUX_IN-1:0] mux_choice_inv,
  input wire logic [2:0] mux_count,
  input wire logic mux_out,
  // Comparator
  input wire logic [CMP_IN-1:0] cmp_in,
  input wire logic [CMP_IN-1:0] cmp_inv,
  input wire logic [3:0] cmp_count,
  input wire logic [CMP_IN-1:0] cmp_const,
  input wire clo_pkg::clo_rel_e cmp_rel,
  input wire logic cmp_signal_mode,
  input wire logic [SIG_W-1:0] operand_a_bits,
  input wire logic [SIG_W-1:0] operand_a_inv,
  input wire logic [SIG_W-1:0] operand_b_bits,
  input wire logic [SIG_W-1:0] operand_b_inv,
  input wire logic cmp_out
);
  logic [GATE_IN-1:0] g_eff;
  logic g_lsb;
  logic [MUX_IN-1:0] m_sel;
  logic [MUX_IN-1:0] m_dat;
  logic [CMP_IN-1:0] c_eff;
  logic [SIG_W-1:0] a_eff;
  logic [SIG_W-1:0] b_eff;
  // Inputs as the operators see them after inversion
  assign g_eff = gate_in ^ gate_inv;
  assign g_lsb = g_eff[0];
  assign m_sel = mux_choice_lines ^ mux_choice_inv;
  assign m_dat = mux_data ^ mux_data_inv;
  assign c_eff = cmp_in ^ cmp_inv;
  assign a_eff = operand_a_bits ^ operand_a_inv;
  assign b_eff = operand_b_bits ^ operand_b_inv;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_and;
    gate_func == clo_pkg::CLO_FUNC_AND && gate_count == 4'h8
      |=> gate_out == &$past(g_eff);
  endproperty
  a_and: assert property (p_and)
    else $error("and result wrong");
  property p_or;
    gate_func == clo_pkg::CLO_FUNC_OR && gate_count == 4'h8
      |=> gate_out == |$past(g_eff);
  endproperty
  a_or: assert property (p_or)
    else $error("or result wrong");
  property p_xor;
    gate_func == clo_pkg::CLO_FUNC_XOR && gate_count == 4'h8
      |=> gate_out == ^$past(g_eff);
  endproperty
  a_xor: assert property (p_xor)
    else $error("parity result wrong");
  property p_not;
    gate_func == clo_pkg::CLO_FUNC_NOT |=> gate_out != $past(g_lsb);
  endproperty
  a_not: assert property (p_not)
    else $error("inverter result wrong");
  property p_mux_sel;
    mux_count == 3'h4 && $onehot(m_sel)
      |=> mux_out == |($past(m_sel) & $past(m_dat));
  endproperty
  a_mux_sel: assert property (p_mux_sel)
    else $error("mux passed wrong input");
  property p_mux_low;
    mux_count == 3'h4 && !$onehot(m_sel) |=> !mux_out;
  endproperty
  a_mux_low: assert property (p_mux_low)
    else $error("mux not forced low");
  property p_cmp_lt;
    !cmp_signal_mode && cmp_rel == clo_pkg::CLO_REL_LT && cmp_count == 4'h8
      |=> cmp_out == ($past(c_eff) < $past(cmp_const));
  endproperty
  a_cmp_lt: assert property (p_cmp_lt)
    else $error("constant compare wrong");
  property p_cmp_sig;
    cmp_signal_mode && cmp_rel == clo_pkg::CLO_REL_GE
      |=> cmp_out == ($past(a_eff) >= $past(b_eff));
  endproperty
  a_cmp_sig: assert property (p_cmp_sig)
    else $error("signal compare wrong");
  property p_mac_off;
    macro_out_disable |=> !macro_out;
  endproperty
  a_mac_off: assert property (p_mac_off)
    else $error("macro output not removed");
endmodule
`default_nettype wire

// ### sim/configurable_logic_operators_tb.sv
// Self-checking bench for the logic operator bank
`timescale 1ns/1ns
`default_nettype none
module configurable_logic_operators_tb;
  logic clk_sys, nrst, src_en, macro_final_sr, macro_out_disable;
  logic macro_first_gate_result_output_en, macro_second_gate_result_output_en, cmp_signal_mode;
  logic [7:0] src_req, gate_in, gate_inv, macro_in, macro_inv;
  logic [7:0] cmp_in, cmp_inv, cmp_const, e;
  logic [3:0] gate_count, cmp_count, mux_data, mux_data_inv;
  logic [3:0] mux_choice_lines, mux_choice_inv, operand_a_bits;
  logic [3:0] operand_a_inv, operand_b_bits, operand_b_inv;
  logic [2:0] macro_count1, macro_count2, mux_count, mx;
  clo_pkg::clo_func_e gate_func, macro_func1, macro_func2, macro_func3;
  clo_pkg::clo_rel_e cmp_rel;
  logic gate_out, macro_out, first_gate_result_output;
  logic second_gate_result_output, mux_out, cmp_out;
  int err_count, samples_checked, cycles;
  logic [7:0] pat [6] = '{8'h03, 8'hFF, 8'h7F, 8'h01, 8'h00, 8'hFC};

  clo_src u_src (.clk_sys, .src_en, .src_req, .gate_in);
  clo_operators dut (.clk_sys, .nrst, .gate_in, .gate_inv, .gate_count,
    .gate_func, .gate_out, .macro_in, .macro_inv, .macro_count1,
    .macro_count2, .macro_func1, .macro_func2, .macro_func3,
    .macro_final_sr, .macro_out_disable, .macro_first_gate_result_output_en, .macro_second_gate_result_output_en,
    .macro_out, .first_gate_result_output, .second_gate_result_output,
    .mux_data, .mux_data_inv, .mux_choice_lines, .mux_choice_inv,
    .mux_count, .mux_out, .cmp_in, .cmp_inv, .cmp_count, .cmp_const,
    .cmp_rel, .cmp_signal_mode, .operand_a_bits, .operand_a_inv,
    .operand_b_bits, .operand_b_inv, .cmp_out);

  // Scan clock, 50 ns period
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Reference gate over the lowest c effective bits
  function automatic logic ev(input int f, input logic [7:0] x, input int c);
    logic [7:0] m;
    m = 8'hFF >> (8 - c);
    case (f)
      0: return &(x | ~m);
      1: return !(&(x | ~m));
      2: return |(x & m);
      3: return !(|(x & m));
      4: return ^(x & m);
      5: return !(^(x & m));
      default: return !x[0];
    endcase
  endfunction

  // Reference relation
  function automatic logic re(input int r, input int a, input int b);
    case (r)
      0: return a < b;
      1: return a >= b;
      2: return a > b;
      3: return a <= b;
      4: return a == b;
      default: return a != b;
    endcase
  endfunction

  task automatic chk(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Every gate type at the smallest and largest width, some inverted
  task automatic t_gate;
    for (int f = 0; f < 7; f++) begin
      for (int k = 0; k < 2; k++) begin
        for (int i = 0; i < 6; i++) begin
          src_req = pat[i];
          gate_inv = k ? 8'h80 : 8'h02;
          gate_count = k ? 4'h8 : 4'h2;
          gate_func = clo_pkg::clo_func_e'(f);
          @(negedge clk_sys);
          e = pat[i] ^ gate_inv;
          chk(gate_out, ev(f, e, k ? 8 : 2));
        end
      end
    end
  endtask

  // Two-level macro, with and without a bypassed first gate
  task automatic t_macro;
    int c1, c2;
    logic g1, g2;
    macro_first_gate_result_output_en = 1'h1;
    macro_second_gate_result_output_en = 1'h1;
    for (int b = 0; b < 2; b++) begin
      c1 = b ? 1 : 3;
      c2 = b ? 7 : 2;
      for (int f = 0; f < 36; f++) begin
        for (int i = 0; i < 4; i++) begin
          macro_in = pat[i] ^ {4'h0, b[0], 3'h0};
          macro_inv = i[0] ? 8'h02 : 8'h00;
          macro_count1 = 3'(c1);
          macro_count2 = 3'(c2);
          macro_func1 = clo_pkg::clo_func_e'(f % 6);
          macro_func2 = clo_pkg::clo_func_e'((f + 3) % 6);
          macro_func3 = clo_pkg::clo_func_e'(f / 6);
          @(negedge clk_sys);
          e = macro_in ^ macro_inv;
          g1 = (c1 == 1) ? e[0] : ev(f % 6, e, c1);
          g2 = ev((f + 3) % 6, e >> c1, c2);
          chk(first_gate_result_output, g1);
          chk(second_gate_result_output, g2);
          chk(macro_out, ev(f / 6, {6'h00, g2, g1}, 2));
        end
      end
    end
    macro_out_disable = 1'h1;
    macro_first_gate_result_output_en = 1'h0;
    macro_second_gate_result_output_en = 1'h0;
    // All-high inputs would raise every result, so any leak shows
    macro_func3 = clo_pkg::CLO_FUNC_AND;
    macro_in = 8'hFF;
    @(negedge clk_sys);
    chk(macro_out, 1'h0);
    chk(first_gate_result_output | second_gate_result_output, 1'h0);
    // Final stage as memory: set, hold, reset, both (reset wins)
    macro_out_disable = 1'h0;
    macro_final_sr = 1'h1;
    macro_inv = 8'h00;
    macro_count1 = 3'h1;
    macro_count2 = 3'h1;
    for (int i = 0; i < 6; i++) begin
      mx = 3'(i % 4 == 0 ? 1 : (i % 4 == 1 ? 0 : i % 4));
      macro_in = {5'h00, mx};
      @(negedge clk_sys);
      chk(macro_out, i == 0 || i == 1 || i == 4 || i == 5);
    end
    macro_final_sr = 1'h0;
  endtask

  // Every choice pattern at four and two inputs
  task automatic t_mux;
    logic [3:0] m, ce;
    for (int k = 0; k < 2; k++) begin
      for (int ch = 0; ch < 32; ch++) begin
        mux_count = k ? 3'h2 : 3'h4;
        mux_choice_lines = 4'(ch);
        mux_choice_inv = k ? 4'h3 : 4'h0;
        mux_data = ch[4] ? 4'hA : 4'h5;
        mux_data_inv = k ? 4'h6 : 4'h0;
        @(negedge clk_sys);
        m = k ? 4'h3 : 4'hF;
        ce = (mux_choice_lines ^ mux_choice_inv) & m;
        chk(mux_out, $onehot(ce) && |(ce & (mux_data ^ mux_data_inv)));
      end
    end
  endtask

  // Constant mode at five and eight bits, then signal mode
  task automatic t_cmp;
    logic [7:0] v [4] = '{8'h19, 8'h1A, 8'h1B, 8'hFA};
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 6; r++) begin
        for (int i = 0; i < 6; i++) begin
          cmp_signal_mode = s[1];
          cmp_rel = clo_pkg::clo_rel_e'(r);
          cmp_count = s[0] ? 4'h8 : 4'h5;
          cmp_const = s[0] ? 8'h96 : 8'h1A;
          cmp_inv = s[0] ? 8'hFF : 8'h00;
          cmp_in = v[i % 4] ^ cmp_inv ^ (s[0] ? 8'h8C : 8'h00);
          operand_a_bits = 4'(i * 3);
          operand_a_inv = s[0] ? 4'hF : 4'h0;
          operand_b_bits = 4'h9;
          operand_b_inv = s[0] ? 4'h1 : 4'h0;
          @(negedge clk_sys);
          e = (cmp_in ^ cmp_inv) & (s[0] ? 8'hFF : 8'h1F);
          if (s[1]) begin
            chk(cmp_out, re(r, operand_a_bits ^ operand_a_inv,
              operand_b_bits ^ operand_b_inv));
          end else begin
            chk(cmp_out, re(r, e, cmp_const));
          end
        end
      end
    end
  endtask

  // Reset in mid-run clears outputs at once
  task automatic t_rst;
    gate_func = clo_pkg::CLO_FUNC_AND;
    gate_count = 4'h2;
    gate_inv = 8'h00;
    src_req = 8'h03;
    @(negedge clk_sys);
    chk(gate_out, 1'h1);
    nrst = 1'h0;
    #1;
    chk(gate_out, 1'h0);
    @(negedge clk_sys);
    nrst = 1'h1;
    @(negedge clk_sys);
    chk(gate_out, 1'h1);
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    {nrst, src_en, macro_final_sr, macro_out_disable, macro_first_gate_result_output_en} = '0;
    {macro_second_gate_result_output_en, cmp_signal_mode, src_req, gate_inv, macro_in} = '0;
    {macro_inv, cmp_in, cmp_inv, cmp_const, gate_count, cmp_count} = '0;
    {mux_data, mux_data_inv, mux_choice_lines, mux_choice_inv} = '0;
    {operand_a_bits, operand_a_inv, operand_b_bits, operand_b_inv} = '0;
    {macro_count1, macro_count2, mux_count} = '0;
    gate_func = clo_pkg::CLO_FUNC_AND;
    macro_func1 = clo_pkg::CLO_FUNC_AND;
    macro_func2 = clo_pkg::CLO_FUNC_AND;
    macro_func3 = clo_pkg::CLO_FUNC_AND;
    cmp_rel = clo_pkg::CLO_REL_LT;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    src_en = 1'h1;
    repeat (10) @(negedge clk_sys);
    nrst = 1'h1;
    t_gate();
    t_macro();
    t_mux();
    t_cmp();
    t_rst();
    close_out();
  end
endmodule

bind clo_operators clo_monitor #(.GATE_IN(GATE_IN), .MUX_IN(MUX_IN),
  .CMP_IN(CMP_IN), .SIG_W(SIG_W)) u_mon (.clk_sys, .nrst, .gate_in,
  .gate_inv, .gate_count, .gate_func, .gate_out, .macro_out_disable,
  .macro_out, .mux_data, .mux_data_inv, .mux_choice_lines,
  .mux_choice_inv, .mux_count, .mux_out, .cmp_in, .cmp_inv, .cmp_count,
  .cmp_const, .cmp_rel, .cmp_signal_mode, .operand_a_bits, .operand_a_inv,
  .operand_b_bits, .operand_b_inv, .cmp_out);
`default_nettype wire
